/* inc/link_speed_pkg.sv */
// Constants and carrier types for the link speed control block
// Notes on behaviour
// - Supports both rates; target speed resets high
// - Target high advertises both rates
// - After reset, train first at low rate
// - Downstream ports auto-upgrade on DL_Active only
// - Inhibit bit blocks initial automatic upgrade
// - Initial upgrade never sets bandwidth status
// - Current speed field reports running rate
// - Upgrade after full retrain if partner capable
// - Software retrain upgrades only if partner recorded
// - Reliability downgrade keeps advertising high rate
// - Target low plus retrain drops high advertisement
// - Partner speed requests honoured if this port advertises high rate
// - Failed upgrade returns low, no self retry
// - Autonomous speed disable reads zero, no effect
// - Autonomous change training bit sent zero
// - Partner autonomous change sets autonomous status on downstream ports
// - Record partner speeds; self-initiated upgrades only within record, partner-requested moves not checked against it
// - Unsupported request: recovery without speed change
// - Interrupt enable bit gates bandwidth notification
// - Reliability downgrade, partner change set status
// - Retrain write in run state sets bandwidth status on downstream ports
// - Full retrain sends state machine to Detect
// - Full retrain leaves bandwidth status unchanged
package link_speed_pkg;

  // Link speed encodings, as in the link status speed field
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [3:0] SPEED_5G0 = 4'h2;
  localparam logic [3:0] TARGET_SPEED_RESET = SPEED_5G0;
  // Bit 6 of the fourth training-set symbol
  localparam int TS_AUTO_CHANGE_BIT = 6;
  localparam logic [7:0] TS_RATE_GEN1 = 8'h02;
  localparam logic [7:0] TS_RATE_GEN12 = 8'h06;
  localparam logic AUTO_SPEED_DISABLE_VALUE = 1'h0;
  // Cycles to wait for the physical layer to settle a speed change
  localparam int SETTLE_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;

  // Events reported by the physical layer, one-cycle pulses
  typedef struct packed {
    logic detect_entry;
    logic l0_reached;
    logic cfg_entry;
    logic speed_ok;
    logic speed_fail;
    logic lock_fail;
    logic unreliable;
    logic partner_req;
    logic partner_auto;
  } phy_event_s;

  // Requests to the link state machine
  typedef struct packed {
    logic goto_detect;
    logic goto_recovery;
    logic speed_change;
    logic [3:0] speed;
  } phy_req_s;

endpackage

/* rtl/pulse_sync.sv */
// Two-stage synchroniser for level inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pulse_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage is read only by the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;

endmodule
`default_nettype wire

/* rtl/partner_rate_rec.sv */
// Record of the link partner's advertised data rates
`timescale 1ns/1ps
`default_nettype none
module partner_rate_rec (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_capture,
  input wire logic i_clear,
  input wire logic i_rx_gen2,
  output logic o_partner_gen2
);

  logic gen2_reg;
  logic gen2_next;

  // Latest advertisement overrides; detect forgets the old record
  always_comb begin
    gen2_next = gen2_reg;
    if (i_clear) begin
      gen2_next = 1'b0;
    end
    if (i_capture) begin
      gen2_next = i_rx_gen2;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gen2_reg <= 1'b0;
    end else begin
      gen2_reg <= gen2_next;
    end
  end

  assign o_partner_gen2 = gen2_reg;

endmodule
`default_nettype wire

/* rtl/link_speed_ctrl.sv */
// Per-port link speed negotiation and bandwidth status control
`timescale 1ns/1ps
`default_nettype none
module link_speed_ctrl #(
  parameter int SETTLE = link_speed_pkg::SETTLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_downstream,
  input wire logic [3:0] i_target_link_speed,
  input wire logic i_initial_speed_change_inhibit,
  input wire logic i_link_retrain_request,
  input wire logic i_full_retrain_request,
  input wire logic i_bw_status_clear,
  input wire logic i_auto_bw_status_clear,
  input wire logic i_bandwidth_mgmt_irq_enable,
  input wire logic i_dl_active,
  input wire link_speed_pkg::phy_event_s i_phy_event,
  input wire logic i_rx_gen2,
  output link_speed_pkg::phy_req_s o_phy_req,
  output logic [7:0] o_ts_rate_id,
  output logic o_ts_auto_change,
  output logic [3:0] o_current_link_speed,
  output logic o_autonomous_speed_disable,
  output logic o_bandwidth_mgmt_status,
  output logic o_autonomous_bandwidth_status,
  output logic o_bw_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronised DL_Active input and recorded partner rate

  logic dl_active_s;
  logic partner_gen2;

  pulse_sync #(.WIDTH(1)) u_dl_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_dl_active),
    .o_sync(dl_active_s)
  );

  partner_rate_rec u_rec (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_capture(i_phy_event.cfg_entry),
    .i_clear(i_phy_event.detect_entry),
    .i_rx_gen2(i_rx_gen2),
    .o_partner_gen2(partner_gen2)
  );

  ////////////////////////////////////////////////////////////////////////
  // Speed control state machine

  typedef enum logic [2:0] {
    ST_TRAIN,
    ST_WAIT_DL,
    ST_RUN,
    ST_CHANGE,
    ST_RECOV
  } speed_state_e;

  speed_state_e state_reg, state_next;
  logic [3:0] speed_reg, speed_next;
  logic adv_gen2_reg, adv_gen2_next;
  logic initial_reg, initial_next;
  logic [15:0] cnt_reg, cnt_next;
  logic bw_reg, bw_next;
  logic abw_reg, abw_next;
  link_speed_pkg::phy_req_s req;
  logic target_high;

  assign target_high = (i_target_link_speed == link_speed_pkg::SPEED_5G0);

  // The other supported rate; request and partner moves share it
  function automatic logic [3:0] other_speed(input logic [3:0] s);
    return (s == link_speed_pkg::SPEED_5G0) ? link_speed_pkg::SPEED_2G5 :
      link_speed_pkg::SPEED_5G0;
  endfunction

  // Next state, speed and advertisement
  always_comb begin
    state_next = state_reg;
    speed_next = speed_reg;
    adv_gen2_next = adv_gen2_reg;
    initial_next = initial_reg;
    cnt_next = cnt_reg;
    req = '0;
    req.speed = speed_reg;
    if (i_full_retrain_request) begin
      req.goto_detect = 1'b1;
      state_next = ST_TRAIN;
      speed_next = link_speed_pkg::SPEED_2G5;
    end else begin
      unique case (state_reg)
        // Train to L0 at the low rate first
        ST_TRAIN: begin
          speed_next = link_speed_pkg::SPEED_2G5;
          initial_next = 1'b1;
          if (i_phy_event.l0_reached) begin
            state_next = ST_WAIT_DL;
          end
        end
        ST_WAIT_DL: begin
          if (dl_active_s) begin
            state_next = ST_RUN;
            // Upstream ports never self-upgrade
            if (i_downstream && target_high && partner_gen2 &&
                !i_initial_speed_change_inhibit) begin
              state_next = ST_CHANGE;
              cnt_next = '0;
            end else begin
              initial_next = 1'b0;
            end
          end
        end
        ST_RUN: begin
          initial_next = 1'b0;
          if (i_link_retrain_request) begin
            adv_gen2_next = target_high;
            cnt_next = '0;
            // Upgrade only toward a recorded partner rate
            if (target_high && partner_gen2 &&
                speed_reg == link_speed_pkg::SPEED_2G5) begin
              state_next = ST_CHANGE;
            end else if (!target_high &&
                         speed_reg == link_speed_pkg::SPEED_5G0) begin
              state_next = ST_CHANGE;
            end else begin
              state_next = ST_RECOV;
            end
          end else if (i_phy_event.unreliable &&
                       speed_reg == link_speed_pkg::SPEED_5G0) begin
            speed_next = link_speed_pkg::SPEED_2G5;
          end else if (i_phy_event.partner_req && adv_gen2_reg) begin
            speed_next = other_speed(speed_reg);
          end
        end
        // Request Recovery.Speed and wait for the result
        ST_CHANGE: begin
          req.goto_recovery = 1'b1;
          req.speed_change = 1'b1;
          req.speed = other_speed(speed_reg);
          cnt_next = cnt_reg + 16'h0001;
          if (i_phy_event.speed_ok) begin
            speed_next = req.speed;
            state_next = ST_RUN;
          end else if (i_phy_event.speed_fail || i_phy_event.lock_fail ||
                       cnt_reg >= 16'(SETTLE)) begin
            speed_next = link_speed_pkg::SPEED_2G5;
            state_next = ST_RUN;
          end
        end
        // Recovery pass without a speed change
        ST_RECOV: begin
          req.goto_recovery = 1'b1;
          state_next = ST_RUN;
        end
        default: begin
          state_next = ST_TRAIN;
        end
      endcase
    end
  end

  // Bandwidth status flags; set wins over clear
  always_comb begin
    bw_next = bw_reg;
    abw_next = abw_reg;
    if (i_bw_status_clear) begin
      bw_next = 1'b0;
    end
    if (i_auto_bw_status_clear) begin
      abw_next = 1'b0;
    end
    if (i_downstream && !i_full_retrain_request) begin
      if (i_link_retrain_request && state_reg == ST_RUN) begin
        bw_next = 1'b1;
      end
      if (state_reg == ST_RUN && !i_link_retrain_request &&
          i_phy_event.unreliable &&
          speed_reg == link_speed_pkg::SPEED_5G0) begin
        bw_next = 1'b1;
      end
      // A refused partner request changes nothing, so flags stay
      if (state_reg == ST_RUN && i_phy_event.partner_req &&
          adv_gen2_reg) begin
        if (i_phy_event.partner_auto) begin
          abw_next = 1'b1;
        end else begin
          bw_next = 1'b1;
        end
      end
      // Initial upgrade and lock failures leave the status alone
    end
  end

  // Speed group registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_TRAIN;
      speed_reg <= link_speed_pkg::SPEED_2G5;
      adv_gen2_reg <= 1'b1;
      initial_reg <= 1'b1;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      speed_reg <= speed_next;
      adv_gen2_reg <= adv_gen2_next;
      initial_reg <= initial_next;
      cnt_reg <= cnt_next;
    end
  end

  // Status flag registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bw_reg <= 1'b0;
      abw_reg <= 1'b0;
    end else begin
      bw_reg <= bw_next;
      abw_reg <= abw_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Advertisement follows target unless a reliability drop kept it high
  assign o_ts_rate_id = adv_gen2_reg ? link_speed_pkg::TS_RATE_GEN12 :
    link_speed_pkg::TS_RATE_GEN1;
  assign o_ts_auto_change = 1'b0;
  assign o_autonomous_speed_disable =
    link_speed_pkg::AUTO_SPEED_DISABLE_VALUE;
  assign o_current_link_speed = speed_reg;
  assign o_phy_req = req;
  assign o_bandwidth_mgmt_status = bw_reg;
  assign o_autonomous_bandwidth_status = abw_reg;
  assign o_bw_irq = bw_reg && i_bandwidth_mgmt_irq_enable &&
    i_downstream;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  // One clock and one reset for every check below
  default clocking cb_main @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence seq_retrain_run;
    state_reg == ST_RUN && i_link_retrain_request &&
      !i_full_retrain_request && i_downstream;
  endsequence

  // Upgrade attempt refused by the partner or lost on symbol lock
  sequence seq_change_failed;
    state_reg == ST_CHANGE && !i_phy_event.speed_ok &&
      (i_phy_event.speed_fail || i_phy_event.lock_fail) &&
      !i_full_retrain_request;
  endsequence

  sequence seq_back_low;
    speed_reg == link_speed_pkg::SPEED_2G5 && state_reg == ST_RUN;
  endsequence

  AST_RETRAIN_SETS_BW: assert property (
    seq_retrain_run |=> bw_reg)
    else $error("retrain did not set bandwidth status");

  AST_FULL_TO_DETECT: assert property (
    i_full_retrain_request |-> o_phy_req.goto_detect
      ##1 (state_reg == ST_TRAIN))
    else $error("full retrain did not go to detect");

  AST_FULL_KEEPS_BW: assert property (
    i_full_retrain_request && !i_bw_status_clear |=> $stable(bw_reg))
    else $error("full retrain changed bandwidth status");

  AST_TRAIN_LOW: assert property (
    state_reg == ST_WAIT_DL |-> speed_reg == link_speed_pkg::SPEED_2G5)
    else $error("trained above low rate");

  AST_UPSTREAM_NO_AUTO: assert property (
    state_reg == ST_WAIT_DL && !i_downstream && !i_full_retrain_request
      |=> state_reg != ST_CHANGE)
    else $error("upstream port self-upgraded");

  AST_INHIBIT: assert property (
    state_reg == ST_WAIT_DL && i_initial_speed_change_inhibit
      |=> state_reg != ST_CHANGE)
    else $error("inhibited initial upgrade started");

  AST_NO_UNRECORDED: assert property (
    state_reg == ST_CHANGE && o_phy_req.speed == link_speed_pkg::SPEED_5G0
      |-> partner_gen2)
    else $error("upgrade without partner record");

  AST_FAIL_LOW: assert property (
    seq_change_failed |=> seq_back_low)
    else $error("failed upgrade did not return low");

  AST_INITIAL_NO_BW: assert property (
    state_reg == ST_CHANGE && initial_reg && !bw_reg |=> !bw_reg)
    else $error("initial upgrade set bandwidth status");

  AST_IRQ: assert property (
    o_bw_irq |-> bw_reg && i_bandwidth_mgmt_irq_enable)
    else $error("interrupt without status and enable");

  AST_TS_BIT: assert property (
    !o_ts_auto_change && !o_autonomous_speed_disable)
    else $error("autonomous bits not zero");

endmodule
`default_nettype wire

/* verif/link_partner_model.sv */
// Behavioural model of the far end of the link
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire link_speed_pkg::phy_req_s i_phy_req,
  input wire logic i_adv_gen2,
  input wire logic i_fail,
  input wire logic i_slow,
  input wire logic i_train,
  output link_speed_pkg::phy_event_s o_phy_event,
  output logic o_rx_gen2
);
  logic [3:0] wait_cnt;
  logic [2:0] step;
  logic up_ok;

  // A move up works only when the partner offers the high rate and i_fail is low
  assign up_ok = (i_phy_req.speed == link_speed_pkg::SPEED_2G5) ||
    (i_adv_gen2 && !i_fail);

  ////////////////////////////////////////////////////////////////////////////
  // Speed change answers and training sequence
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wait_cnt <= '0;
      step <= '0;
      o_phy_event <= '0;
      o_rx_gen2 <= 1'b0;
    end else begin
      o_phy_event <= '0;
      // Line toggles outside capture so a stale value never helps
      o_rx_gen2 <= !o_rx_gen2;
      if (i_phy_req.goto_recovery && i_phy_req.speed_change) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt == (i_slow ? 4'h3 : 4'h0)) begin
          o_phy_event.speed_ok <= up_ok;
          o_phy_event.lock_fail <= !up_ok;
        end
      end else begin
        wait_cnt <= '0;
      end
      // Detect, then configuration with advertisement, then L0
      if (step != 3'h0) begin
        step <= step + 3'h1;
      end else if (i_train || i_phy_req.goto_detect) begin
        step <= 3'h1;
      end
      o_phy_event.detect_entry <= (step == 3'h1);
      if (step == 3'h3) begin
        o_phy_event.cfg_entry <= 1'b1;
        o_rx_gen2 <= i_adv_gen2;
      end
      o_phy_event.l0_reached <= (step == 3'h5);
    end
  end
endmodule
`default_nettype wire

/* verif/test_link_speed_ctrl.sv */
// Self-checking bench for the link speed control block
`timescale 1ns/1ps
`default_nettype none
module test_link_speed_ctrl;
  logic i_clk, i_rst, ds, inh, link_retrain_request, full_retrain_request, bw_clr, abw_clr, irq_en, dl;
  logic adv, fail, slow, train, sc_q, ts_auto, autonomous_speed_disable, bw, abw, irq, rx_gen2;
  logic [3:0] target_link_speed, spd;
  logic [7:0] rate;
  link_speed_pkg::phy_event_s ev_p, ev_tb, ev;
  link_speed_pkg::phy_req_s req;
  int bad_count = 0;
  int num_checks = 0;
  int sc_cnt = 0;
  int cycles = 0;

  assign ev = link_speed_pkg::phy_event_s'(ev_p | ev_tb);

  link_speed_ctrl #(.SETTLE(6)) u_link_speed_ctrl (.i_clk(i_clk),
    .i_rst(i_rst), .i_downstream(ds), .i_target_link_speed(target_link_speed),
    .i_initial_speed_change_inhibit(inh), .i_link_retrain_request(link_retrain_request),
    .i_full_retrain_request(full_retrain_request), .i_bw_status_clear(bw_clr),
    .i_auto_bw_status_clear(abw_clr), .i_bandwidth_mgmt_irq_enable(irq_en),
    .i_dl_active(dl), .i_phy_event(ev), .i_rx_gen2(rx_gen2),
    .o_phy_req(req), .o_ts_rate_id(rate), .o_ts_auto_change(ts_auto),
    .o_current_link_speed(spd), .o_autonomous_speed_disable(autonomous_speed_disable),
    .o_bandwidth_mgmt_status(bw), .o_autonomous_bandwidth_status(abw),
    .o_bw_irq(irq));

  link_partner_model u_link_partner_model (.i_clk(i_clk), .i_rst(i_rst),
    .i_phy_req(req), .i_adv_gen2(adv), .i_fail(fail), .i_slow(slow),
    .i_train(train), .o_phy_event(ev_p), .o_rx_gen2(rx_gen2));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counts speed change attempts; cuts a hang short
  always @(posedge i_clk) begin
    if (req.speed_change && !sc_q) sc_cnt++;
    sc_q = req.speed_change;
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task tally_and_finish;
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Drivers: inputs move 1 ns after the rising edge
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  task pev(input logic [8:0] e);
    ev_tb = link_speed_pkg::phy_event_s'(e);
    tick(1);
    ev_tb = '0;
  endtask

  task rst_dut(input logic d, input logic h);
    i_rst = 1'b1;
    ds = d;
    inh = h;
    target_link_speed = 4'h2;
    {link_retrain_request, full_retrain_request, bw_clr, abw_clr, irq_en, dl, adv, fail, slow, train} = '0;
    ev_tb = '0;
    tick(2);
    i_rst = 1'b0;
    sc_cnt = 0;
    tick(1);
  endtask

  // Partner trains to L0, then the data link comes up
  task up(input logic g);
    adv = g;
    pulse(train);
    tick(7);
    dl = 1'b1;
  endtask

  // Bounded wait, no check of its own
  task wspd(input logic [3:0] e);
    for (int i = 0; i < 80 && spd !== e; i++) tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_boot;
    rst_dut(1'b1, 1'b0);
    chk("speed", spd, 4'h1);
    chk("rate", rate, 8'h06);
    chk("ts_auto", ts_auto, 1'b0);
    chk("autonomous_speed_disable", autonomous_speed_disable, 1'b0);
    slow = 1'b1;
    up(1'b1);
    wspd(4'h2);
    chk("speed", spd, 4'h2);
    chk("bw", bw, 1'b0);
  endtask

  // Upstream port, then downstream with inhibit set; target left alone
  task t_hold;
    for (int k = 0; k < 2; k++) begin
      rst_dut(k[0], k[0]);
      up(1'b1);
      tick(30);
      chk("speed", spd, 4'h1);
      chk("changes", 8'(sc_cnt), 8'h0);
      pulse(link_retrain_request);
      tick(1);
      chk("bw", bw, k[0]);
    end
  endtask

  task t_nogen2;
    rst_dut(1'b1, 1'b0);
    up(1'b0);
    tick(30);
    chk("speed", spd, 4'h1);
    pulse(link_retrain_request);
    chk("recov", {req.goto_recovery, req.speed_change}, 2'b10);
    tick(1);
    chk("bw", bw, 1'b1);
    tick(30);
    chk("speed", spd, 4'h1);
    chk("changes", 8'(sc_cnt), 8'h0);
  endtask

  task t_unrel;
    t_boot;
    pev(9'h004);
    tick(1);
    chk("speed", spd, 4'h1);
    chk("rate", rate, 8'h06);
    chk("bw", bw, 1'b1);
    chk("irq", irq, 1'b0);
    irq_en = 1'b1;
    tick(1);
    chk("irq", irq, 1'b1);
    pulse(bw_clr);
    tick(1);
    chk("bw", bw, 1'b0);
    chk("irq", irq, 1'b0);
  endtask

  // Failed upgrade: no retry, yet software may upgrade later
  task t_fail;
    rst_dut(1'b1, 1'b0);
    fail = 1'b1;
    up(1'b1);
    tick(40);
    chk("speed", spd, 4'h1);
    chk("bw", bw, 1'b0);
    chk("changes", 8'(sc_cnt), 8'h1);
    chk("rate", rate, 8'h06);
    fail = 1'b0;
    pulse(link_retrain_request);
    wspd(4'h2);
    chk("speed", spd, 4'h2);
  endtask

  task t_low;
    t_boot;
    target_link_speed = 4'h1;
    pulse(link_retrain_request);
    wspd(4'h1);
    chk("speed", spd, 4'h1);
    chk("rate", rate, 8'h02);
    chk("bw", bw, 1'b1);
  endtask

  task t_full;
    t_boot;
    pulse(link_retrain_request);
    tick(20);
    full_retrain_request = 1'b1;
    #1;
    chk("detect", req.goto_detect, 1'b1);
    tick(1);
    full_retrain_request = 1'b0;
    dl = 1'b0;
    tick(4);
    chk("speed", spd, 4'h1);
    tick(6);
    dl = 1'b1;
    wspd(4'h2);
    chk("speed", spd, 4'h2);
    chk("bw", bw, 1'b1);
  endtask

  // Partner-led change, marked autonomous and not
  task t_partner;
    for (int k = 0; k < 2; k++) begin
      rst_dut(1'b1, 1'b1);
      up(1'b1);
      tick(10);
      pev(k ? 9'h002 : 9'h003);
      wspd(4'h2);
      chk("speed", spd, 4'h2);
      chk("abw", abw, !k[0]);
      chk("bw", bw, k[0]);
      pulse(abw_clr);
      tick(1);
      chk("abw", abw, 1'b0);
      chk("bw", bw, k[0]);
    end
  endtask

  initial begin
    t_boot;
    t_hold;
    t_nogen2;
    t_unrel;
    t_fail;
    t_low;
    t_full;
    t_partner;
    tally_and_finish();
  end
endmodule
`default_nettype wire
